// [inc/pwm_dac_params.svh]
// Constants for the pulse-width DAC drive and converter port
`ifndef PWM_DAC_PARAMS_SVH
`define PWM_DAC_PARAMS_SVH

// ==========================================================
// Clocking
`define CLK_FREQ_HZ     20000000
`define OSC_FREQ_HZ     8000000
`define OSC_DIVIDE      4
`define OSC_STEP        (`OSC_FREQ_HZ / 1000000)
`define OSC_MODULO      (`CLK_FREQ_HZ / 1000000)
`define ONESHOT_NS      2000
`define ONESHOT_CYCLES  ((`ONESHOT_NS * (`CLK_FREQ_HZ / 1000000)) / 1000)

// ==========================================================
// Interval timer
`define TIMER_FULL      15'h5e1f
`define TSEL_HI_BIT     0
`define TSEL_CH_BIT     1

// ==========================================================
// Address blocks on the upper five address bits
`define BLK_TIMER       5'h10
`define BLK_OFFSET      5'h11
`define BLK_REVISION    5'h12
`define BLK_SELF        5'h13
`define BLK_TRIGGER     5'h14
`define BLK_CONVERTER   5'h15

// ==========================================================
// Data bus fields and reset values
`define OFFSET_BIT      7
`define STATUS_BIT      6
`define HI_SIGN_BIT     4
`define HI_OVER_BIT     5
`define MON_SEL_MSB     3
`define DIV_OFF_RESET   1'b1
`define MON_SEL_RESET   4'h0
`define REVISION_CODE   8'h01

`endif

// [inc/pwm_dac_pkg.sv]
// Types shared by the pulse-width DAC drive and its interval timer
package pwm_dac_pkg;

    typedef struct packed {
        logic [14:0]      cnt;
        logic [1:0][14:0] duty;
        logic [1:0][7:0]  low;
        logic [1:0]       wave;
    } timer_state_t;

    typedef struct packed {
        logic [6:0] addr1;
        logic [6:0] addr2;
        logic [7:0] data1;
        logic [7:0] data2;
        logic       wr1;
        logic       wr2;
        logic       rd1;
        logic       rd2;
        logic       st1;
        logic       st2;
        logic [7:0] adc1;
        logic [7:0] adc2;
        logic       wr_prev;
        logic       st_prev;
        logic       div_off;
        logic [4:0] acc;
        logic [1:0] quarter;
        logic [5:0] shot;
        logic [1:0] drive;
        logic       offset_en;
        logic [3:0] mon_sel;
        logic       run;
        logic [7:0] rdata;
        logic       oe;
    } top_state_t;

endpackage

// [inc/timer_bus_if.sv]
// Carrier between the port logic and the interval timer
`timescale 1ns/1ps
interface timer_bus_if;
    logic       ce;
    logic       tick;
    logic       load;
    logic [1:0] sel;
    logic [7:0] data;
    logic [1:0] wave;

    modport ctrl (output ce, output tick, output load, output sel, output data, input wave);
    modport tmr  (input ce, input tick, input load, input sel, input data, output wave);
endinterface

// [verilog/interval_timer.sv]
// Two-channel programmable-duty interval timer
`timescale 1ns/1ps
`include "pwm_dac_params.svh"
module interval_timer (
    input  wire logic  clock,
    input  wire logic  rst,
    timer_bus_if.tmr   bus
);
    import pwm_dac_pkg::*;

    timer_state_t st_reg;
    timer_state_t st_next;
    logic [1:0]   high_now;
    logic         ch;

    // ==========================================================
    // Per-channel compare
    genvar g;
    for (g = 0; g < 2; g++) begin : g_ch
        assign high_now[g] = st_reg.cnt < st_reg.duty[g];
    end

    assign ch = bus.sel[`TSEL_CH_BIT];

    always_comb begin
        st_next = st_reg;
        if (bus.ce) begin
            if (bus.tick) begin
                // One period is TIMER_FULL ticks, so the full count never goes low
                st_next.cnt  = (st_reg.cnt == `TIMER_FULL - 15'h0001) ? 15'h0000
                             : st_reg.cnt + 15'h0001;
                st_next.wave = high_now;
            end
            if (bus.load) begin
                if (!bus.sel[`TSEL_HI_BIT]) begin
                    st_next.low[ch] = bus.data;
                end else begin
                    // Only the addressed channel changes
                    st_next.duty[ch] = {bus.data[6:0], st_reg.low[ch]};
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus.wave = st_reg.wave;

    // ==========================================================
    // Checks
    property p_zero_duty_low;
        @(posedge clock) disable iff (rst)
        (st_reg.duty[0] == 15'h0000) && bus.ce && bus.tick |=> !st_reg.wave[0];
    endproperty
    a_zero_duty_low: assert property (p_zero_duty_low) else $error("zero duty went high");

    property p_full_duty_high;
        @(posedge clock) disable iff (rst)
        (st_reg.duty[1] == `TIMER_FULL) && bus.ce && bus.tick |=> st_reg.wave[1];
    endproperty
    a_full_duty_high: assert property (p_full_duty_high) else $error("full duty went low");

    property p_other_channel_kept;
        @(posedge clock) disable iff (rst)
        bus.ce && bus.load && !ch |=> $stable(st_reg.duty[1]);
    endproperty
    a_other_channel_kept: assert property (p_other_channel_kept) else $error("channel 1 disturbed");
endmodule

// [verilog/pwm_dac_drive_and_adc_port.sv]
// Guarded-bus port: PWM DAC drive timers, offset and monitor latches, converter handshake
// ==========================================================
// Notes on behaviour
// - Divide 8 MHz by four for 2 MHz.
// - Two independent 83 Hz programmable-duty waves.
// - Count 0 low, 24095 high, linear between.
// - 15-bit counts loaded as two bytes.
// - Two low address bits pick timer register.
// - Decode upper bits, acknowledge own addresses.
// - Load timer only on select plus write.
// - Any timer access starts the divider.
// - Reset stops divider until first timer access.
// - Drive outputs resampled on 2 MHz clock.
// - Clock stops, timeout forces drive low.
// - Write captures data bit 7 as offset.
// - Revision read drives code, else released.
// - Result is 12 bits, sign, overrange.
// - Write loads monitor select; reset clears it.
// - Trigger write sets run/hold high.
// - Status falling clears run, holding result.
// - Trigger read returns status on bit 6.
// - Address bit 0 picks low or high byte.
// - Converter read enables chip and data.
// - Status low and run/hold clear means result ready.
`timescale 1ns/1ps
`include "pwm_dac_params.svh"
module pwm_dac_drive_and_adc_port (
    input  wire logic       CLOCK,
    input  wire logic       RST,
    input  wire logic       CE,
    input  wire logic [6:0] GUARDED_ADDRESS_BUS,
    input  wire logic [7:0] GUARDED_DATA_BUS_IN,
    output logic      [7:0] GUARDED_DATA_BUS_OUT,
    output logic      [7:0] GUARDED_DATA_BUS_OE,
    input  wire logic       WR_N,
    input  wire logic       RD_N,
    output logic            ACK_N,
    output logic      [1:0] DRIVE,
    output logic            OFFSET_ENABLE,
    output logic      [3:0] MON_SELECT,
    output logic            RUN_HOLD,
    input  wire logic       CONV_STATUS,
    output logic            CONV_READY,
    output logic            CONV_CE_N,
    output logic            LOW_BYTE_SELECT_N,
    output logic            HIGH_BYTE_SELECT_N,
    input  wire logic [7:0] CONV_DATA
);
    import pwm_dac_pkg::*;

    localparam logic [5:0] OSC_STEP_W = 6'(`OSC_STEP);
    localparam logic [5:0] OSC_MOD_W  = 6'(`OSC_MODULO);
    localparam logic [1:0] QUARTER_LAST = 2'(`OSC_DIVIDE - 1);
    localparam logic [5:0] SHOT_LOAD  = 6'(`ONESHOT_CYCLES);

    top_state_t  st_reg;
    top_state_t  st_next;
    timer_bus_if tbus ();

    logic       wr_act;
    logic       rd_act;
    logic       wr_edge;
    logic       st_fall;
    logic [4:0] blk;
    logic       hit_timer;
    logic       hit_offset;
    logic       hit_rev;
    logic       hit_self;
    logic       hit_trig;
    logic       hit_conv;
    logic       hit_any;
    logic [5:0] acc_sum;
    logic       osc_tick;
    logic       tick2m;

    // ==========================================================
    // Decode on synchronised pins
    assign wr_act  = !st_reg.wr2;
    assign rd_act  = !st_reg.rd2;
    assign wr_edge = wr_act && !st_reg.wr_prev;
    assign st_fall = st_reg.st_prev && !st_reg.st2;
    assign blk     = st_reg.addr2[6:2];

    assign hit_timer  = blk == `BLK_TIMER;
    assign hit_offset = blk == `BLK_OFFSET;
    assign hit_rev    = blk == `BLK_REVISION;
    assign hit_self   = blk == `BLK_SELF;
    assign hit_trig   = blk == `BLK_TRIGGER;
    assign hit_conv   = blk == `BLK_CONVERTER;
    assign hit_any    = hit_timer || hit_offset || hit_rev || hit_self || hit_trig || hit_conv;

    // Acknowledge follows the strobe while one of our blocks is addressed
    assign ACK_N = !((wr_act || rd_act) && hit_any);

    // ==========================================================
    // Timer clock: 8 MHz phase accumulator, then divide by four
    // Accumulator ticks are uneven at 20 MHz; the average rate is exact.
    assign acc_sum  = {1'b0, st_reg.acc} + OSC_STEP_W;
    assign osc_tick = acc_sum >= OSC_MOD_W;
    assign tick2m   = CE && !st_reg.div_off && osc_tick
                   && (st_reg.quarter == QUARTER_LAST);

    assign tbus.ce   = CE;
    assign tbus.tick = tick2m;
    assign tbus.load = CE && wr_edge && hit_timer;
    assign tbus.sel  = st_reg.addr2[1:0];
    assign tbus.data = st_reg.data2;

    interval_timer u_timer (
        .clock (CLOCK),
        .rst   (RST),
        .bus   (tbus.tmr)
    );

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        if (CE) begin
            st_next.addr1   = GUARDED_ADDRESS_BUS;
            st_next.addr2   = st_reg.addr1;
            st_next.data1   = GUARDED_DATA_BUS_IN;
            st_next.data2   = st_reg.data1;
            st_next.wr1     = WR_N;
            st_next.wr2     = st_reg.wr1;
            st_next.rd1     = RD_N;
            st_next.rd2     = st_reg.rd1;
            st_next.st1     = CONV_STATUS;
            st_next.st2     = st_reg.st1;
            st_next.adc1    = CONV_DATA;
            st_next.adc2    = st_reg.adc1;
            st_next.wr_prev = wr_act;
            st_next.st_prev = st_reg.st2;

            if ((wr_act || rd_act) && hit_timer) begin
                st_next.div_off = 1'b0;
            end

            if (!st_reg.div_off) begin
                st_next.acc = osc_tick ? 5'(acc_sum - OSC_MOD_W) : acc_sum[4:0];
                if (osc_tick) begin
                    st_next.quarter = st_reg.quarter + 2'h1;
                end
            end else begin
                st_next.acc     = 5'h00;
                st_next.quarter = 2'h0;
            end

            // Retriggerable timeout; expiry forces the drive low
            if (tick2m) begin
                st_next.shot  = SHOT_LOAD;
                st_next.drive = tbus.wave;
            end else if (st_reg.shot != 6'h00) begin
                st_next.shot = st_reg.shot - 6'h01;
                if (st_reg.shot == 6'h01) begin
                    st_next.drive = 2'h0;
                end
            end

            if (wr_edge && hit_offset) begin
                st_next.offset_en = st_reg.data2[`OFFSET_BIT];
            end
            if (wr_edge && hit_self) begin
                st_next.mon_sel = st_reg.data2[`MON_SEL_MSB:0];
            end

            // Trigger write wins over a status edge in the same cycle
            if (st_fall) begin
                st_next.run = 1'b0;
            end
            if (wr_edge && hit_trig) begin
                st_next.run = 1'b1;
            end

            st_next.oe    = rd_act && (hit_rev || hit_trig || hit_conv);
            st_next.rdata = 8'h00;
            if (rd_act && hit_rev) begin
                st_next.rdata = `REVISION_CODE;
            end else if (rd_act && hit_trig) begin
                st_next.rdata[`STATUS_BIT] = st_reg.st2;
            end else if (rd_act && hit_conv) begin
                if (!st_reg.addr2[0]) begin
                    st_next.rdata = st_reg.adc2;
                end else begin
                    // High byte: four magnitude bits, sign, overrange
                    st_next.rdata[3:0]          = st_reg.adc2[3:0];
                    st_next.rdata[`HI_SIGN_BIT] = st_reg.adc2[`HI_SIGN_BIT];
                    st_next.rdata[`HI_OVER_BIT] = st_reg.adc2[`HI_OVER_BIT];
                end
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            st_reg         <= '0;
            st_reg.wr1     <= 1'b1;
            st_reg.wr2     <= 1'b1;
            st_reg.rd1     <= 1'b1;
            st_reg.rd2     <= 1'b1;
            st_reg.wr_prev <= 1'b0;
            st_reg.div_off <= `DIV_OFF_RESET;
            st_reg.mon_sel <= `MON_SEL_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign DRIVE                = st_reg.drive;
    assign OFFSET_ENABLE        = st_reg.offset_en;
    assign MON_SELECT           = st_reg.mon_sel;
    assign RUN_HOLD             = st_reg.run;
    assign GUARDED_DATA_BUS_OUT = st_reg.rdata;
    assign GUARDED_DATA_BUS_OE  = {8{st_reg.oe}};
    assign CONV_READY           = !st_reg.run && !st_reg.st2;
    assign CONV_CE_N            = !(rd_act && hit_conv);
    assign LOW_BYTE_SELECT_N    = !(hit_conv && !st_reg.addr2[0]);
    assign HIGH_BYTE_SELECT_N   = !(hit_conv && st_reg.addr2[0]);

    // ==========================================================
    // Checks
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    property p_tick_spacing;
        tick2m |=> !tick2m [*8];
    endproperty
    a_tick_spacing: assert property (p_tick_spacing) else $error("2 MHz ticks too close");

    property p_ack_on_hit;
        (wr_act || rd_act) && hit_any |-> !ACK_N;
    endproperty
    a_ack_on_hit: assert property (p_ack_on_hit) else $error("missing acknowledge");

    property p_load_gated;
        tbus.load |-> wr_edge && hit_timer && $past(!wr_act);
    endproperty
    a_load_gated: assert property (p_load_gated) else $error("timer load without write");

    property p_access_starts;
        CE && (wr_act || rd_act) && hit_timer |=> !st_reg.div_off ##1 !st_reg.div_off;
    endproperty
    a_access_starts: assert property (p_access_starts) else $error("divider not started");

    property p_stopped_no_tick;
        st_reg.div_off |-> !tick2m;
    endproperty
    a_stopped_no_tick: assert property (p_stopped_no_tick) else $error("tick while stopped");

    property p_drive_aligned;
        $changed(DRIVE) |-> $past(tick2m) || ($past(st_reg.shot) == 6'h01);
    endproperty
    a_drive_aligned: assert property (p_drive_aligned) else $error("drive moved off tick");

    property p_timeout_low;
        CE && !tick2m && (st_reg.shot == 6'h01) |=> (DRIVE == 2'h0);
    endproperty
    a_timeout_low: assert property (p_timeout_low) else $error("drive alive after timeout");

    property p_offset_capture;
        CE && wr_edge && hit_offset |=> OFFSET_ENABLE == $past(st_reg.data2[`OFFSET_BIT]);
    endproperty
    a_offset_capture: assert property (p_offset_capture) else $error("offset not captured");

    property p_rev_read;
        CE && rd_act && hit_rev |=> st_reg.oe && (GUARDED_DATA_BUS_OUT == `REVISION_CODE);
    endproperty
    a_rev_read: assert property (p_rev_read) else $error("revision not driven");

    property p_bus_released;
        CE && !rd_act |=> (GUARDED_DATA_BUS_OE == 8'h00);
    endproperty
    a_bus_released: assert property (p_bus_released) else $error("bus driven without read");

    property p_mon_load;
        CE && wr_edge && hit_self |=> MON_SELECT == $past(st_reg.data2[3:0]);
    endproperty
    a_mon_load: assert property (p_mon_load) else $error("monitor select not loaded");

    property p_trigger_run;
        CE && wr_edge && hit_trig |=> RUN_HOLD;
    endproperty
    a_trigger_run: assert property (p_trigger_run) else $error("run not set");

    property p_status_stops;
        CE && st_fall && !(wr_edge && hit_trig) |=> !RUN_HOLD;
    endproperty
    a_status_stops: assert property (p_status_stops) else $error("run not cleared");

    property p_status_read;
        CE && rd_act && hit_trig |=> GUARDED_DATA_BUS_OUT[`STATUS_BIT] == $past(st_reg.st2);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bit wrong");

    property p_conv_enable;
        rd_act && hit_conv |-> !CONV_CE_N && (LOW_BYTE_SELECT_N != HIGH_BYTE_SELECT_N);
    endproperty
    a_conv_enable: assert property (p_conv_enable) else $error("converter not enabled");

    // Held state: nothing moves without its own strobe, and drive holds while CE is low
    property p_div_stays_off;
        st_reg.div_off && !(CE && (wr_act || rd_act) && hit_timer) |=> st_reg.div_off;
    endproperty
    a_div_stays_off: assert property (p_div_stays_off) else $error("divider started alone");

    property p_run_held_low;
        !RUN_HOLD && !(CE && wr_edge && hit_trig) |=> !RUN_HOLD;
    endproperty
    a_run_held_low: assert property (p_run_held_low) else $error("run set without trigger");

    property p_offset_hold;
        !(CE && wr_edge && hit_offset) |=> $stable(OFFSET_ENABLE);
    endproperty
    a_offset_hold: assert property (p_offset_hold) else $error("offset moved alone");

    property p_mon_hold;
        !(CE && wr_edge && hit_self) |=> $stable(MON_SELECT);
    endproperty
    a_mon_hold: assert property (p_mon_hold) else $error("monitor select moved alone");

    property p_drive_frozen;
        !CE |=> $stable(DRIVE);
    endproperty
    a_drive_frozen: assert property (p_drive_frozen) else $error("drive moved while frozen");

    // Readout bytes: unused bit positions must read as zero
    property p_status_clean;
        CE && rd_act && hit_trig
        |=> (GUARDED_DATA_BUS_OUT[7] == 1'b0) && (GUARDED_DATA_BUS_OUT[5:0] == 6'h00);
    endproperty
    a_status_clean: assert property (p_status_clean) else $error("status byte not clean");

    property p_low_byte;
        CE && rd_act && hit_conv && !st_reg.addr2[0]
        |=> GUARDED_DATA_BUS_OUT == $past(st_reg.adc2);
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte wrong");

    property p_high_byte;
        CE && rd_act && hit_conv && st_reg.addr2[0]
        |=> (GUARDED_DATA_BUS_OUT[7:6] == 2'h0)
            && (GUARDED_DATA_BUS_OUT[5:0] == $past(st_reg.adc2[5:0]));
    endproperty
    a_high_byte: assert property (p_high_byte) else $error("high byte wrong");

    // Loads are edge-triggered, so two in a row sit a full strobe apart
    c_timer_load: cover property (tbus.load ##[1:20] tbus.load);
    c_conversion: cover property (wr_edge && hit_trig ##[1:200] st_fall);
    c_timeout: cover property (st_reg.shot == 6'h01 && !tick2m);
    c_high_byte: cover property (rd_act && hit_conv && st_reg.addr2[0]);
endmodule

// [verif/adc_model.sv]
// Behavioural model of the external a/d converter behind the port
`timescale 1ns/1ps
module adc_model (
    input  wire logic        clock,
    input  wire logic        run_hold,
    input  wire logic        chip_en_n,
    input  wire logic        low_sel_n,
    input  wire logic        high_sel_n,
    input  wire logic [13:0] result,
    input  wire logic [7:0]  conv_cycles,
    output logic             status,
    output logic [7:0]       data
);
    logic       armed = 1'b0;
    logic [7:0] left  = 8'h00;
    logic [7:0] idle  = 8'h5a;

    initial status = 1'b0;

    // ==========================================================
    // Conversion: busy from run rising, low once the count runs out
    always @(posedge clock) begin
        idle <= ~idle;
        if (run_hold && !armed) begin
            armed  <= 1'b1;
            status <= 1'b1;
            left   <= conv_cycles;
        end else if (status && left != 8'h00) begin
            left <= left - 8'h01;
        end else begin
            status <= 1'b0;
        end
        if (!run_hold) begin
            armed <= 1'b0;
        end
    end

    // ==========================================================
    // Byte outputs; deselected pins toggle so stale data never matches
    always_comb begin
        if (!chip_en_n && !low_sel_n) begin
            data = result[7:0];
        end else if (!chip_en_n && !high_sel_n) begin
            data = {2'b00, result[13:12], result[11:8]};
        end else begin
            data = idle;
        end
    end
endmodule

// [verif/pwm_dac_drive_and_adc_port_tb.sv]
// Self-checking bench for the PWM DAC drive and converter port
`timescale 1ns/1ps
`include "pwm_dac_params.svh"
module pwm_dac_drive_and_adc_port_tb;
    logic        clock       = 1'b0;
    logic        rst         = 1'b1;
    logic        ce          = 1'b1;
    logic [6:0]  addr        = 7'h00;
    logic [7:0]  din         = 8'h00;
    logic        wr_n        = 1'b1;
    logic        rd_n        = 1'b1;
    logic [13:0] result      = 14'h0000;
    logic [7:0]  conv_cycles = 8'h20;
    logic [15:0] rnd         = 16'hff15;
    logic [7:0]  dout, oe, cdata, d, o;
    logic        ack_n, run_hold, status, ready, cce_n, lsel_n, hsel_n, ak, cen, offset_en;
    logic [1:0]  drive;
    logic [3:0]  mon;
    int          error_cnt   = 0;
    int          comparisons = 0;

    always #25 clock = ~clock;

    pwm_dac_drive_and_adc_port dut (
        .CLOCK(clock), .RST(rst), .CE(ce), .GUARDED_ADDRESS_BUS(addr),
        .GUARDED_DATA_BUS_IN(din), .GUARDED_DATA_BUS_OUT(dout), .GUARDED_DATA_BUS_OE(oe),
        .WR_N(wr_n), .RD_N(rd_n), .ACK_N(ack_n), .DRIVE(drive), .OFFSET_ENABLE(offset_en),
        .MON_SELECT(mon), .RUN_HOLD(run_hold), .CONV_STATUS(status), .CONV_READY(ready),
        .CONV_CE_N(cce_n), .LOW_BYTE_SELECT_N(lsel_n), .HIGH_BYTE_SELECT_N(hsel_n),
        .CONV_DATA(cdata)
    );

    adc_model converter (
        .clock(clock), .run_hold(run_hold), .chip_en_n(cce_n), .low_sel_n(lsel_n),
        .high_sel_n(hsel_n), .result(result), .conv_cycles(conv_cycles),
        .status(status), .data(cdata)
    );

    // ==========================================================
    // Helpers
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    function automatic logic [7:0] hi_of(input logic [13:0] r);
        return {2'b00, r[13:12], r[11:8]};
    endfunction

    task automatic end_sim;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t level %b expected %b", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    task automatic roll;
        rnd = nxt(rnd);
    endtask

    // Address and data settle three cycles ahead of the strobe
    task automatic bus_wr(input logic [6:0] a, input logic [7:0] v);
        @(posedge clock);
        addr <= a;
        din  <= v;
        cyc(3);
        wr_n <= 1'b0;
        cyc(4);
        wr_n <= 1'b1;
        cyc(4);
        #1;
    endtask

    // Strobe held long enough for converter bytes through both syncs
    task automatic bus_rd(input logic [6:0] a, output logic [7:0] rd, output logic [7:0] ro,
                          output logic rak, output logic rce);
        @(posedge clock);
        addr <= a;
        cyc(3);
        rd_n <= 1'b0;
        cyc(8);
        #1;
        rd  = dout;
        ro  = oe;
        rak = ack_n;
        rce = cce_n;
        @(posedge clock);
        rd_n <= 1'b1;
        cyc(4);
        #1;
        chk_val(oe, 8'h00);
    endtask

    task automatic write_duty(input logic ch, input logic [14:0] v);
        roll();
        bus_wr({`BLK_TIMER, ch, 1'b0}, v[7:0]);
        bus_wr({`BLK_TIMER, ch, 1'b1}, {rnd[0], v[14:8]});
    endtask

    // ==========================================================
    // Watchdog
    initial begin
        cyc(20000);
        error_cnt++;
        end_sim();
    end

    // ==========================================================
    // Main sequence
    initial begin
        cyc(6);
        rst <= 1'b0;
        cyc(2);
        #1;
        chk_val({drive, offset_en, mon, run_hold}, 8'h00);
        chk_bit(ack_n, 1'b1);
        bus_rd({`BLK_REVISION, 2'b00}, d, o, ak, cen);
        chk_val(d, `REVISION_CODE);
        chk_val(o, 8'hff);
        chk_bit(ak, 1'b0);
        bus_rd({5'h03, 2'b10}, d, o, ak, cen);
        chk_bit(ak, 1'b1);
        chk_val(o, 8'h00);
        bus_rd({`BLK_SELF, 2'b00}, d, o, ak, cen);
        chk_bit(ak, 1'b0);
        chk_val(o, 8'h00);
        for (int i = 0; i < 4; i++) begin
            roll();
            bus_wr({`BLK_OFFSET, rnd[9:8]}, {i[0], rnd[6:0]});
            chk_bit(offset_en, i[0]);
            bus_wr({`BLK_SELF, rnd[11:10]}, rnd[7:0]);
            chk_val({4'h0, mon}, {4'h0, rnd[3:0]});
            bus_wr({5'h0c, rnd[1:0]}, ~rnd[7:0]);
            chk_val({3'h0, offset_en, mon}, {3'h0, i[0], rnd[3:0]});
        end
        // Frozen by clock enable: a write strobe must leave no trace
        @(posedge clock);
        ce <= 1'b0;
        bus_wr({`BLK_OFFSET, 2'b00}, 8'h00);
        @(posedge clock);
        ce <= 1'b1;
        cyc(6);
        #1;
        chk_bit(offset_en, 1'b1);
        // Only the steady ends are checked: a full period is far too long to run
        write_duty(1'b1, `TIMER_FULL);
        write_duty(1'b0, 15'h0000);
        cyc(100);
        chk_val({6'h00, drive}, 8'h02);
        write_duty(1'b0, `TIMER_FULL);
        cyc(100);
        chk_val({6'h00, drive}, 8'h03);
        write_duty(1'b1, 15'h0000);
        bus_rd({`BLK_TIMER, 2'b01}, d, o, ak, cen);
        cyc(100);
        chk_val({6'h00, drive}, 8'h01);
        for (int k = 0; k < 3; k++) begin
            roll();
            result      <= rnd[13:0];
            conv_cycles <= {4'h2, rnd[3:0]};
            bus_wr({`BLK_TRIGGER, rnd[15:14]}, rnd[7:0]);
            chk_bit(run_hold, 1'b1);
            chk_bit(ready, 1'b0);
            d = 8'hff;
            for (int p = 0; p < 30 && d[6] !== 1'b0; p++) begin
                bus_rd({`BLK_TRIGGER, 2'b00}, d, o, ak, cen);
                if (p == 0) begin
                    chk_bit(d[6], 1'b1);
                end
            end
            chk_bit(d[6], 1'b0);
            cyc(6);
            #1;
            chk_bit(run_hold, 1'b0);
            chk_bit(ready, 1'b1);
            bus_rd({`BLK_CONVERTER, 2'b00}, d, o, ak, cen);
            chk_val(d, rnd[7:0]);
            chk_bit(cen, 1'b0);
            bus_rd({`BLK_CONVERTER, 2'b01}, d, o, ak, cen);
            chk_val(d, hi_of(rnd[13:0]));
            chk_val(o, 8'hff);
        end
        @(posedge clock);
        rst <= 1'b1;
        cyc(2);
        #1;
        chk_val({drive, offset_en, mon, run_hold}, 8'h00);
        @(posedge clock);
        rst <= 1'b0;
        cyc(4);
        end_sim();
    end
endmodule
